// ===== conv_ctrl_pkg.sv
// Package for the converter command and status block.
// Assumes one clock domain shared by the bus slave and the analog core.
package conv_ctrl_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_CONVERSION_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CONVERSION_COMMAND = 8'h04;
   localparam logic [7:0] OFS_CONVERSION_STATUS  = 8'h08;
   localparam logic [7:0] OFS_EVENT_FLAGS        = 8'h10;
   localparam logic [7:0] OFS_EVENT_MASK         = 8'h14;

   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int FILTER_LSB   = 4;
   localparam int SINGLE_AFTER_SCAN_PRIORITY_BIT = 3;
   localparam logic [1:0] FILTER_BYPASS = 2'h0;
   localparam logic [1:0] FILTER_DECOUPLING_CAP_FILTER  = 2'h1;
   localparam logic [1:0] FILTER_RC     = 2'h2;

   // ----------------------------------------
   // Command strobe bits
   // ----------------------------------------
   localparam int CMD_ONE_SHOT_BEGIN = 0;
   localparam int CMD_ONE_SHOT_HALT  = 1;
   localparam int CMD_SCAN_BEGIN     = 2;
   localparam int CMD_SCAN_HALT      = 3;

   // ----------------------------------------
   // Status bits
   // ----------------------------------------
   localparam int ST_ONE_SHOT_ACT   = 0;
   localparam int ST_SCAN_ACT       = 1;
   localparam int ST_ONE_SHOT_REF   = 8;
   localparam int ST_SCAN_REF       = 9;
   localparam int ST_WARM           = 12;
   localparam int ST_ONE_SHOT_VALID = 16;
   localparam int ST_SCAN_VALID     = 17;
   localparam int ST_ORIGIN_LSB     = 24;

   // ----------------------------------------
   // Event flag bits and reset values
   // ----------------------------------------
   localparam int EV_ONE_SHOT_DONE = 0;
   localparam int EV_SCAN_DONE     = 1;
   localparam logic [1:0]  EV_RESET   = 2'h0;
   localparam logic [31:0] REG_RESET  = 32'h0000_0000;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic start;
      logic scan;
      logic halt;
   } core_req_s;

   typedef struct packed {
      logic       done;
      logic       scan;
      logic       last;
      logic [2:0] channel;
   } core_resp_s;

   typedef struct packed {
      logic converter;
      logic scan_ref;
      logic one_shot_ref;
   } warm_s;

endpackage

// ===== conv_sequencer.sv
// Sequencer deciding which conversion the analog core runs next.
// Assumes the core answers each start with done pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module conv_sequencer
   import conv_ctrl_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic single_pend,
   input  wire logic scan_pend,
   input  wire logic single_after_scan_priority,
   input  wire logic halt_single,
   input  wire logic halt_scan,
   input  wire core_resp_s resp,
   output core_req_s  req,
   output logic       take_single,
   output logic       take_scan,
   output logic       single_busy,
   output logic       scan_busy
);

   typedef enum logic [1:0] {IDLE, SINGLE_RUN, SCAN_RUN} seq_e;

   typedef struct packed {
      seq_e      st;
      core_req_s req;
   } seq_s;

   seq_s cur;
   seq_s next_cur;

   always_comb begin
      next_cur    = cur;
      next_cur.req = '0;
      take_single = 1'b0;
      take_scan   = 1'b0;
      case (cur.st)
         IDLE: begin
            // Scan always wins a free core
            if (scan_pend && !halt_scan) begin
               next_cur.req.start = 1'b1;
               next_cur.req.scan  = 1'b1;
               next_cur.st        = SCAN_RUN;
               take_scan          = 1'b1;
            end else if (single_pend && !single_after_scan_priority && !halt_single) begin
               next_cur.req.start = 1'b1;
               next_cur.st        = SINGLE_RUN;
               take_single        = 1'b1;
            end
         end
         SINGLE_RUN: begin
            // A running single finishes before a waiting scan
            if (halt_single) begin
               next_cur.req.halt = 1'b1;
               next_cur.st       = IDLE;
            end else if (resp.done && !resp.scan) begin
               next_cur.st = IDLE;
            end
         end
         SCAN_RUN: begin
            if (halt_scan) begin
               next_cur.req.halt = 1'b1;
               next_cur.req.scan = 1'b1;
               next_cur.st       = IDLE;
            end else if (resp.done && resp.scan && resp.last) begin
               // Tailgated single goes straight after the sequence
               if (single_pend && single_after_scan_priority && !halt_single) begin
                  next_cur.req.start = 1'b1;
                  next_cur.st        = SINGLE_RUN;
                  take_single        = 1'b1;
               end else begin
                  next_cur.st = IDLE;
               end
            end
         end
         default: next_cur.st = IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur <= '{st: IDLE, req: '0};
      end else begin
         cur <= next_cur;
      end
   end

   assign req         = cur.req;
   assign single_busy = (cur.st == SINGLE_RUN);
   assign scan_busy   = (cur.st == SCAN_RUN);

endmodule
`default_nettype wire

// ===== conv_ctrl.sv
// Converter command and status block with a classic Wishbone slave.
// Assumes the analog core shares CLOCK and reports conversions by done pulses.
//
// Function
// - Filter field 0 bypasses, 1 picks decoupling capacitor, 2 picks RC filter.
// - Without tailgating, scan has priority but waits for a running single.
// - With tailgating, a pending single starts only right after a scan ends.
// - Writing one to command bit 3 halts the scan sequence.
// - Writing one to command bit 2 begins a scan sequence.
// - Writing one to command bit 1 halts the single conversion.
// - Writing one to command bit 0 begins a single conversion.
// - Status field shows the channel of the latest scan result, 0 to 7.
// - Single-ended scan origin code n means input channel n.
// - Differential scan origin codes 0 to 3 mean pairs 0-1 to 6-7.
// - Status bits 1 and 0 show scan and single activity or pending work.
// - Status bit 16 shows single data valid, bit 17 scan data valid.
// - Status bits 12, 9 and 8 show converter and reference warm-up.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl
   import conv_ctrl_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input  wire logic        CLOCK,
   input  wire logic        SYS_RST,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [ADDR_W-1:0] WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic             WB_ACK_O,
   output logic [31:0]      WB_DAT_O,
   output logic             IRQ,
   output logic             FILTER_DECOUPLING_CAP_FILTER_EN,
   output logic             FILTER_RC_EN,
   input  wire logic        DIFF_MODE,
   input  wire warm_s       WARM,
   input  wire core_resp_s  CORE_RESP,
   output core_req_s        CORE_REQ
);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 8 and 32");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [1:0]  filter;
      logic        single_after_scan_priority;
      logic        single_pend;
      logic        scan_pend;
      logic        halt_single;
      logic        halt_scan;
      logic        single_dv;
      logic        scan_dv;
      logic [2:0]  origin;
      logic [1:0]  ev_flags;
      logic [1:0]  ev_mask;
      logic        ack;
      logic [31:0] rdata;
      logic        irq;
      logic        decoupling_cap_filter_en;
      logic        rc_en;
   } ctrl_s;

   ctrl_s cur;
   ctrl_s next_cur;

   logic take_single;
   logic take_scan;
   logic single_busy;
   logic scan_busy;

   // Upper address bits must be zero, so aliases never hit
   function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [7:0] ofs);
      hit = (adr == ADDR_W'(ofs));
   endfunction

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   conv_sequencer u_seq (
      .clk         (CLOCK),
      .rst         (SYS_RST),
      .single_pend (cur.single_pend),
      .scan_pend   (cur.scan_pend),
      .single_after_scan_priority    (cur.single_after_scan_priority),
      .halt_single (cur.halt_single),
      .halt_scan   (cur.halt_scan),
      .resp        (CORE_RESP),
      .req         (CORE_REQ),
      .take_single (take_single),
      .take_scan   (take_scan),
      .single_busy (single_busy),
      .scan_busy   (scan_busy)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic        access;
      logic        wr;
      logic        lane0;
      logic        begin_single;
      logic        begin_scan;
      logic        one_shot_done;
      logic        scan_conv_done;
      logic        scan_seq_done;
      logic [31:0] status;
      logic [31:0] rd;
      logic [1:0]  ev_set;

      access         = 1'b0;
      wr             = 1'b0;
      lane0          = 1'b0;
      begin_single   = 1'b0;
      begin_scan     = 1'b0;
      one_shot_done  = 1'b0;
      scan_conv_done = 1'b0;
      scan_seq_done  = 1'b0;
      status         = 32'h0000_0000;
      rd             = 32'h0000_0000;
      ev_set         = 2'h0;

      next_cur     = cur;
      next_cur.ack = 1'b0;
      next_cur.halt_single = 1'b0;
      next_cur.halt_scan   = 1'b0;

      // One-cycle answer; ack drops in the cycle after it was given
      access = WB_CYC_I && WB_STB_I && !cur.ack;
      wr     = access && WB_WE_I;
      lane0  = WB_SEL_I[0];

      one_shot_done  = CORE_RESP.done && !CORE_RESP.scan && single_busy;
      scan_conv_done = CORE_RESP.done && CORE_RESP.scan && scan_busy;
      scan_seq_done  = scan_conv_done && CORE_RESP.last;

      // Register writes, byte lane 0 carries every writable field
      if (wr && lane0) begin
         if (hit(WB_ADR_I, OFS_CONVERSION_CONTROL)) begin
            next_cur.filter   = WB_DAT_I[FILTER_LSB +: 2];
            next_cur.single_after_scan_priority = WB_DAT_I[SINGLE_AFTER_SCAN_PRIORITY_BIT];
         end else if (hit(WB_ADR_I, OFS_CONVERSION_COMMAND)) begin
            // Zero bits leave activity untouched
            begin_single = WB_DAT_I[CMD_ONE_SHOT_BEGIN];
            begin_scan   = WB_DAT_I[CMD_SCAN_BEGIN];
            next_cur.halt_single = WB_DAT_I[CMD_ONE_SHOT_HALT];
            next_cur.halt_scan   = WB_DAT_I[CMD_SCAN_HALT];
         end else if (hit(WB_ADR_I, OFS_EVENT_MASK)) begin
            next_cur.ev_mask = WB_DAT_I[1:0];
         end
      end

      // Filter selection drives the analog switches
      next_cur.decoupling_cap_filter_en = (next_cur.filter == FILTER_DECOUPLING_CAP_FILTER);
      next_cur.rc_en    = (next_cur.filter == FILTER_RC);

      // Pending work: a begin strobe wins over consumption and halts
      next_cur.single_pend = (cur.single_pend && !take_single && !cur.halt_single)
                             || begin_single;
      next_cur.scan_pend   = (cur.scan_pend && !take_scan && !cur.halt_scan)
                             || begin_scan;

      // Data valid: new begin clears, completion sets and wins
      next_cur.single_dv = (cur.single_dv && !begin_single) || one_shot_done;
      next_cur.scan_dv   = (cur.scan_dv && !begin_scan) || scan_conv_done;

      // Differential results name the pair, not the first channel
      if (scan_conv_done) begin
         if (DIFF_MODE) begin
            next_cur.origin = {1'b0, CORE_RESP.channel[2:1]};
         end else begin
            next_cur.origin = CORE_RESP.channel;
         end
      end

      // Event flags: hardware set wins over a write-one clear
      ev_set[EV_ONE_SHOT_DONE] = one_shot_done;
      ev_set[EV_SCAN_DONE]     = scan_seq_done;
      if (wr && lane0 && hit(WB_ADR_I, OFS_EVENT_FLAGS)) begin
         next_cur.ev_flags = (cur.ev_flags & ~WB_DAT_I[1:0]) | ev_set;
      end else begin
         next_cur.ev_flags = cur.ev_flags | ev_set;
      end
      next_cur.irq = |(next_cur.ev_flags & next_cur.ev_mask);

      // Status word
      status[ST_ONE_SHOT_ACT]   = cur.single_pend || single_busy;
      status[ST_SCAN_ACT]       = cur.scan_pend || scan_busy;
      status[ST_ONE_SHOT_REF]   = WARM.one_shot_ref;
      status[ST_SCAN_REF]       = WARM.scan_ref;
      status[ST_WARM]           = WARM.converter;
      status[ST_ONE_SHOT_VALID] = cur.single_dv;
      status[ST_SCAN_VALID]     = cur.scan_dv;
      status[ST_ORIGIN_LSB +: 3] = cur.origin;

      // Read mux; command word and unmapped addresses read zero
      if (hit(WB_ADR_I, OFS_CONVERSION_CONTROL)) begin
         rd[FILTER_LSB +: 2] = cur.filter;
         rd[SINGLE_AFTER_SCAN_PRIORITY_BIT]    = cur.single_after_scan_priority;
      end else if (hit(WB_ADR_I, OFS_CONVERSION_COMMAND)) begin
         rd = 32'h0000_0000;
      end else if (hit(WB_ADR_I, OFS_CONVERSION_STATUS)) begin
         rd = status;
      end else if (hit(WB_ADR_I, OFS_EVENT_FLAGS)) begin
         rd[1:0] = cur.ev_flags;
      end else if (hit(WB_ADR_I, OFS_EVENT_MASK)) begin
         rd[1:0] = cur.ev_mask;
      end

      if (access) begin
         next_cur.ack   = 1'b1;
         next_cur.rdata = WB_WE_I ? 32'h0000_0000 : rd;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         cur          <= '0;
         cur.filter   <= FILTER_BYPASS;
         cur.ev_flags <= EV_RESET;
         cur.ev_mask  <= EV_RESET;
         cur.rdata    <= REG_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   assign WB_ACK_O        = cur.ack;
   assign WB_DAT_O        = cur.rdata;
   assign IRQ             = cur.irq;
   assign FILTER_DECOUPLING_CAP_FILTER_EN = cur.decoupling_cap_filter_en;
   assign FILTER_RC_EN    = cur.rc_en;

endmodule
`default_nettype wire

// ===== conv_ctrl_assertions.sv
// Checker for the converter command block, watching its top ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_assertions
   import conv_ctrl_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input wire logic              CLOCK,
   input wire logic              SYS_RST,
   input wire logic              WB_CYC_I,
   input wire logic              WB_STB_I,
   input wire logic              WB_WE_I,
   input wire logic [ADDR_W-1:0] WB_ADR_I,
   input wire logic [3:0]        WB_SEL_I,
   input wire logic [31:0]       WB_DAT_I,
   input wire logic              WB_ACK_O,
   input wire logic [31:0]       WB_DAT_O,
   input wire logic              IRQ,
   input wire logic              FILTER_DECOUPLING_CAP_FILTER_EN,
   input wire logic              FILTER_RC_EN,
   input wire logic              DIFF_MODE,
   input wire warm_s             WARM,
   input wire core_resp_s        CORE_RESP,
   input wire core_req_s         CORE_REQ
);
   // ---------------------------------
   // Decode of taken requests
   // ---------------------------------
   logic       req_in, wr, cmd_wr, cmd_rd, ctl_wr, scan_halt_wr, one_halt_wr, scan_end, tg;
   logic [1:0] flt;
   always_comb begin
      req_in = WB_CYC_I && WB_STB_I && !WB_ACK_O;
      wr = req_in && WB_WE_I && WB_SEL_I[0];
      cmd_wr = wr && WB_ADR_I == ADDR_W'(OFS_CONVERSION_COMMAND);
      cmd_rd = req_in && !WB_WE_I && WB_ADR_I == ADDR_W'(OFS_CONVERSION_COMMAND);
      ctl_wr = wr && WB_ADR_I == ADDR_W'(OFS_CONVERSION_CONTROL);
      scan_halt_wr = cmd_wr && WB_DAT_I[CMD_SCAN_HALT];
      one_halt_wr = cmd_wr && WB_DAT_I[CMD_ONE_SHOT_HALT];
      scan_end = CORE_RESP.done && CORE_RESP.scan && CORE_RESP.last;
      flt = WB_DAT_I[FILTER_LSB +: 2];
   end
   // Own copy of tailgating, the control register is not a port
   always_ff @(posedge CLOCK) begin
      if (SYS_RST)
         tg <= 1'b0;
      else if (ctl_wr)
         tg <= WB_DAT_I[SINGLE_AFTER_SCAN_PRIORITY_BIT];
   end
   // ---------------------------------
   // Properties
   // ---------------------------------
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   sequence s_answer;
      WB_ACK_O ##1 !WB_ACK_O;
   endsequence
   chk_ack_pulse:
      assert property (req_in |=> s_answer) else $error("bus answer not one ack");
   chk_cmd_reads_zero:
      assert property (WB_ACK_O && $past(cmd_rd) |-> WB_DAT_O == 32'h0)
         else $error("command read not zero");
   chk_decoupling_cap_filter_select:
      assert property ($past(ctl_wr, 2) |-> FILTER_DECOUPLING_CAP_FILTER_EN == ($past(flt, 2) == FILTER_DECOUPLING_CAP_FILTER))
         else $error("decoupling_cap_filter enable wrong");
   chk_rc_select:
      assert property ($past(ctl_wr, 2) |-> FILTER_RC_EN == ($past(flt, 2) == FILTER_RC))
         else $error("rc enable wrong");
   chk_start_pulse:
      assert property (CORE_REQ.start |=> !CORE_REQ.start) else $error("start too long");
   chk_scan_halt:
      assert property (CORE_REQ.halt && CORE_REQ.scan |-> $past(scan_halt_wr, 2))
         else $error("scan halt without command");
   chk_single_halt:
      assert property (CORE_REQ.halt && !CORE_REQ.scan |-> $past(one_halt_wr, 2))
         else $error("single halt without command");
   chk_tail_start:
      assert property (CORE_REQ.start && !CORE_REQ.scan && tg |-> $past(scan_end))
         else $error("single start not right after scan end");
endmodule
bind conv_ctrl conv_ctrl_assertions #(.ADDR_W(ADDR_W)) i_conv_ctrl_assertions (
   .CLOCK(CLOCK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
   .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .IRQ(IRQ), .FILTER_DECOUPLING_CAP_FILTER_EN(FILTER_DECOUPLING_CAP_FILTER_EN),
   .FILTER_RC_EN(FILTER_RC_EN), .DIFF_MODE(DIFF_MODE), .WARM(WARM),
   .CORE_RESP(CORE_RESP), .CORE_REQ(CORE_REQ));
`default_nettype wire

// ===== conv_core_model.sv
// Behavioural analog core: answers starts with done pulses every lat+1 cycles.
// Assumes requests arrive as one-cycle pulses on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module conv_core_model
   import conv_ctrl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire core_req_s  req,
   input  wire logic [3:0] lat,
   input  wire logic [2:0] nscan,
   output core_resp_s      resp
);
   logic       busy;
   logic       scan;
   logic [2:0] ch;
   logic [3:0] cnt;
   always_ff @(posedge clk) begin
      // Channel toggles between results, so a stale value never looks valid
      resp <= '{1'b0, 1'b0, 1'b0, ~resp.channel};
      if (rst) begin
         busy <= 1'b0;
         resp <= '0;
      end else if (req.halt) begin
         busy <= 1'b0;
      end else if (req.start) begin
         busy <= 1'b1;
         scan <= req.scan;
         ch <= 3'h0;
         cnt <= lat;
      end else if (busy && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else if (busy) begin
         resp <= '{1'b1, scan, scan && ch == nscan, ch};
         ch <= ch + 3'h1;
         cnt <= lat;
         busy <= scan && ch != nscan;
      end
   end
endmodule
`default_nettype wire

// ===== conv_ctrl_bench.sv
// Self-checking bench for the converter command block.
// Assumes package, core model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_bench
   import conv_ctrl_pkg::*;
;
   logic        CLOCK, SYS_RST, cyc, stb, we, diff, ack, irq, dcp, rcf;
   logic [7:0]  adr;
   logic [3:0]  sel, lat;
   logic [2:0]  nscan;
   logic [31:0] dat, dato, rd, seed;
   warm_s       warm;
   core_resp_s  resp;
   core_req_s   req;
   int          n_fail, n_compared, cycles, exp_origin;
   bit          starts[$];
   logic [7:0]  offs[6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1c};

   conv_ctrl i_conv_ctrl (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_ACK_O(ack),
      .WB_DAT_O(dato), .IRQ(irq), .FILTER_DECOUPLING_CAP_FILTER_EN(dcp), .FILTER_RC_EN(rcf),
      .DIFF_MODE(diff), .WARM(warm), .CORE_RESP(resp), .CORE_REQ(req));
   conv_core_model i_conv_core_model (.clk(CLOCK), .rst(SYS_RST), .req(req), .lat(lat),
      .nscan(nscan), .resp(resp));

   initial begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end
   // ---------------------------------
   // Helpers
   // ---------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge CLOCK);
      while (ack !== 1'b1)
         @(posedge CLOCK);
      rd = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic cmd(input int b);
      wb(1'b1, OFS_CONVERSION_COMMAND, 32'h1 << b);
   endtask
   // Hangs here are cut by the cycle ceiling
   task automatic wait_irq();
      while (irq !== 1'b1)
         @(posedge CLOCK);
   endtask
   // Reference model of start order and scan origin
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         report_and_stop();
      end else begin
         if (req.start === 1'b1)
            starts.push_back(req.scan);
         if (resp.done === 1'b1 && resp.scan === 1'b1)
            exp_origin = diff ? 32'(resp.channel[2:1]) : 32'(resp.channel);
      end
   end
   // ---------------------------------
   // Scenarios
   // ---------------------------------
   initial begin
      {SYS_RST, cyc, stb, we, diff, adr, dat, warm} = '0;
      SYS_RST = 1'b1;
      sel = 4'h1;
      lat = 4'h4;
      nscan = 3'h3;
      seed = 32'h92ff;
      repeat (16) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      foreach (offs[i]) begin
         wb(1'b0, offs[i], 32'h0);
         check(rd, 32'h0);
      end
      for (int v = 0; v < 4; v++) begin
         wb(1'b1, OFS_CONVERSION_CONTROL, 32'(v) << FILTER_LSB);
         @(posedge CLOCK);
         check({dcp, rcf}, {v == 1, v == 2});
      end
      wb(1'b1, OFS_EVENT_MASK, 32'h3);
      cmd(CMD_ONE_SHOT_BEGIN);
      wb(1'b0, OFS_CONVERSION_STATUS, 32'h0);
      check(rd, 32'h1);
      wait_irq();
      wb(1'b0, OFS_CONVERSION_STATUS, 32'h0);
      check(rd, 32'h1 << ST_ONE_SHOT_VALID);
      wb(1'b1, OFS_EVENT_MASK, 32'h0);
      @(posedge CLOCK);
      check(irq, 1'b0);
      wb(1'b1, OFS_EVENT_MASK, 32'h3);
      wb(1'b1, OFS_EVENT_FLAGS, 32'h3);
      @(posedge CLOCK);
      check(irq, 1'b0);
      for (int i = 0; i < 4; i++) begin
         rd = rnd();
         nscan <= rd[2:0];
         lat <= {1'b0, rd[5:3]};
         warm <= rd[8:6];
         diff <= i[0];
         cmd(CMD_SCAN_BEGIN);
         wait_irq();
         wb(1'b0, OFS_CONVERSION_STATUS, 32'h0);
         check(rd[26:24], exp_origin[2:0]);
         check({rd[ST_SCAN_VALID], rd[ST_SCAN_ACT]}, 2'h2);
         check({rd[ST_WARM], rd[ST_SCAN_REF], rd[ST_ONE_SHOT_REF]}, warm);
         wb(1'b1, OFS_EVENT_FLAGS, 32'h3);
      end
      lat <= 4'hf;
      nscan <= 3'h7;
      cmd(CMD_SCAN_BEGIN);
      cmd(CMD_SCAN_HALT);
      cmd(CMD_ONE_SHOT_BEGIN);
      cmd(CMD_ONE_SHOT_HALT);
      wb(1'b0, OFS_CONVERSION_STATUS, 32'h0);
      check(rd[1:0], 2'h0);
      starts.delete();
      wb(1'b1, OFS_CONVERSION_COMMAND, 32'h0);
      wb(1'b0, OFS_EVENT_FLAGS, 32'h0);
      check(rd, 32'h0);
      check(32'(starts.size()), 32'h0);
      lat <= 4'h8;
      nscan <= 3'h1;
      wb(1'b1, OFS_EVENT_MASK, 32'h2);
      cmd(CMD_ONE_SHOT_BEGIN);
      cmd(CMD_SCAN_BEGIN);
      wb(1'b0, OFS_CONVERSION_STATUS, 32'h0);
      check(rd[1:0], 2'h3);
      wait_irq();
      check(32'(starts.size()), 32'h2);
      check(32'(starts[0]), 32'h0);
      check(32'(starts[1]), 32'h1);
      wb(1'b1, OFS_EVENT_FLAGS, 32'h3);
      wb(1'b1, OFS_CONVERSION_CONTROL, 32'h1 << SINGLE_AFTER_SCAN_PRIORITY_BIT);
      starts.delete();
      cmd(CMD_ONE_SHOT_BEGIN);
      wb(1'b0, OFS_CONVERSION_STATUS, 32'h0);
      check(32'(rd[0]), 32'h1);
      check(32'(starts.size()), 32'h0);
      wb(1'b1, OFS_EVENT_MASK, 32'h1);
      cmd(CMD_SCAN_BEGIN);
      wait_irq();
      check(32'(starts.size()), 32'h2);
      check(32'(starts[0]), 32'h1);
      check(32'(starts[1]), 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
